// *** uart_core.sv ***
// async serial transceiver: registers, transmitter, receive buffering
//
// Summary of operation
// R1: fixed codes 000..101 halve rate from 76800
// R2: code 110 uses timer source over period
// R3: idle receiver hunts low start level
// R4: sample RT7, RT8, RT9; majority decides
// R5: one or two high stop bits
// R6: optional parity, odd or even
// R7: armed data write fills holding buffer
// R8: transmission start sets empty, pulses interrupt
// R9: line high while disabled or no data
// R10: write without status read is ignored
// R11: frame end loads buffer, full, interrupt
// R12: frame into full buffer sets overrun
// R13: overrun discards new byte, keeps buffer
// R14: receive disable waits for frame end
// R15: parity mismatch sets parity error
// R16: low stop bit sets framing error
// R17: status then data read clears flags
// R18: overrun blocks reception until cleared
// R19: overrun after status read survives
// R20: done flag set on finish, cleared on start
// R21: low start, high stops, parity after data
// R22: shared rate and parity both directions
// R23: sixteen oversample steps per bit
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module uart_core
    import uart_pkg::*;
(
    // clock and reset
    input  wire logic       CLK_IN,
    input  wire logic       NRST_IN,
    // register port
    input  wire logic [1:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    output logic      [7:0] RDATA_OUT,
    // timer source ticks, same clock
    input  wire logic       TIMER_TICK_IN,
    // serial line
    input  wire logic       RXD_IN,
    output logic            TXD_OUT,
    // event pulses
    output logic            TX_IRQ_OUT,
    output logic            RX_IRQ_OUT
);
    typedef struct packed {
        ctrl_s      ctrl;       // serial_control_one
        logic [7:0] period;     // timer_three_period_value
        logic [7:0] rdata;      // read data
        logic [7:0] rx_buf;     // rx_holding_buffer
        logic [7:0] tx_hold;    // tx_holding_buffer
        logic [7:0] tx_sh;      // transmit shifter
        logic       tx_par;     // parity of the byte in flight
        tx_state_e  tx_st;      // transmit position
        logic [3:0] tx_cnt;     // oversample step in bit
        logic [2:0] tx_bit;     // data bit index
        logic       txd;        // line level
        logic       parity_error_flag;       // parity_error_flag
        logic       framing_error_flag;       // framing_error_flag
        logic       oerr;       // overrun flag
        logic       rbfl;       // receive buffer full
        logic       tx_done_flag;       // tx_done_flag
        logic       tx_buffer_empty_flag;       // tx_buffer_empty_flag
        logic       arm_tx;     // status read seen before write
        logic       arm_rx;     // status read seen before read
        logic       oerr_seen;  // overrun visible at status read
        logic       tx_irq;     // tx_interrupt pulse
        logic       rx_irq;     // rx_interrupt pulse
        logic       rxd_s1;     // line sync stage one
        logic       rxd_s2;     // line sync stage two
    } core_s;

    core_s     s_r;             // state
    core_s     s_nxt;           // next state
    logic      tick;            // oversample tick
    logic      rx_done;         // frame finished
    rx_frame_s rx_frame;        // finished frame
    logic      rx_run;          // receiver may start a frame
    logic      wr_data;         // data register write
    logic      rd_data;         // data register read
    logic      rd_stat;         // status register read
    logic      clr_rx;          // armed data read
    logic      tx_go;           // frame start this cycle
    logic [7:0] status;         // status image

    // R22: one rate source serves both directions
    uart_rate_gen u_rate (
        .clk           (CLK_IN),
        .nrst          (NRST_IN),
        .sel_in        (s_r.ctrl.baud_divider_select),
        .timer_tick_in (TIMER_TICK_IN),
        .period_in     (s_r.period),
        .tick_out      (tick)
    );

    // R18: overrun holds the receiver idle
    assign rx_run = s_r.ctrl.receiver_enable_bit && !s_r.oerr;

    uart_rx_frame u_rx (
        .clk       (CLK_IN),
        .nrst      (NRST_IN),
        .tick_in   (tick),
        .rxd_in    (s_r.rxd_s2),
        .run_in    (rx_run),
        .par_en_in (s_r.ctrl.parity_enable),
        .even_in   (s_r.ctrl.parity_even),
        .done_out  (rx_done),
        .frame_out (rx_frame)
    );

    // access decode
    assign wr_data = WR_IN && ADDR_IN == OFS_DATA;
    assign rd_data = RD_IN && ADDR_IN == OFS_DATA;
    assign rd_stat = RD_IN && ADDR_IN == OFS_STATUS;
    // R17: only a data read after a status read clears
    assign clr_rx  = rd_data && s_r.arm_rx;
    assign tx_go   = tick && s_r.tx_st == TX_IDLE && !s_r.tx_buffer_empty_flag
                     && s_r.ctrl.transmitter_enable_bit;
    assign status  = {s_r.parity_error_flag, s_r.framing_error_flag, s_r.oerr, s_r.rbfl,
                      s_r.tx_done_flag, s_r.tx_buffer_empty_flag, 2'b00};

    // registers, flags and transmitter
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tx_irq = 1'b0;
        s_nxt.rx_irq = 1'b0;
        // line synchroniser
        s_nxt.rxd_s1 = RXD_IN;
        s_nxt.rxd_s2 = s_r.rxd_s1;

        // register writes
        if (WR_IN)
        begin
            unique case (ADDR_IN)
                OFS_CTRL:   s_nxt.ctrl = ctrl_s'(WDATA_IN);
                OFS_PERIOD: s_nxt.period = WDATA_IN;
                OFS_DATA:
                begin
                    // R10: unarmed or full-buffer write is dropped
                    if (s_r.arm_tx && s_r.tx_buffer_empty_flag)
                    begin
                        // R7: byte waits for the shifter
                        s_nxt.tx_hold = WDATA_IN;
                        s_nxt.tx_buffer_empty_flag = 1'b0;
                    end
                    s_nxt.arm_tx = 1'b0;
                end
                OFS_STATUS: ;
            endcase
        end

        // register reads, data one cycle later
        if (RD_IN)
        begin
            unique case (ADDR_IN)
                OFS_CTRL:   s_nxt.rdata = s_r.ctrl;
                OFS_STATUS: s_nxt.rdata = status;
                OFS_DATA:   s_nxt.rdata = s_r.rx_buf;
                OFS_PERIOD: s_nxt.rdata = s_r.period;
            endcase
        end
        if (rd_stat)
        begin
            s_nxt.arm_tx = 1'b1;
            s_nxt.arm_rx = 1'b1;
            s_nxt.oerr_seen = s_r.oerr;
        end
        if (rd_data)
            s_nxt.arm_rx = 1'b0;
        if (clr_rx)
        begin
            s_nxt.parity_error_flag = 1'b0;
            s_nxt.framing_error_flag = 1'b0;
            s_nxt.rbfl = 1'b0;
            // R19: a later overrun stays set
            if (s_r.oerr_seen)
                s_nxt.oerr = 1'b0;
        end

        // received frame; sets win over the clear above
        if (rx_done)
        begin
            if (s_r.rbfl && !clr_rx)
            begin
                // R12: buffer still unread
                s_nxt.oerr = 1'b1;
                // R13: new byte dropped, buffer kept
            end
            else
            begin
                // R11: data only into the buffer
                s_nxt.rx_buf = rx_frame.data;
                s_nxt.rbfl = 1'b1;
                s_nxt.parity_error_flag = rx_frame.par_err;
                s_nxt.framing_error_flag = rx_frame.frm_err;
                s_nxt.rx_irq = 1'b1;
            end
        end

        // transmitter, one bit per sixteen ticks
        if (tx_go)
        begin
            // R8: shifter takes the byte, buffer empties
            s_nxt.tx_sh = s_r.tx_hold;
            s_nxt.tx_par = parity_bit(s_r.tx_hold, s_r.ctrl.parity_even);
            s_nxt.tx_buffer_empty_flag = 1'b1;
            s_nxt.tx_irq = 1'b1;
            // R20: a new frame clears done
            s_nxt.tx_done_flag = 1'b0;
            s_nxt.tx_st = TX_START;
            s_nxt.tx_cnt = 4'h0;
        end
        else if (tick && s_r.tx_st != TX_IDLE)
        begin
            // R23: sixteen oversample steps per bit
            s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
            if (s_r.tx_cnt == RT_END)
            begin
                unique case (s_r.tx_st)
                    TX_START:
                    begin
                        s_nxt.tx_st = TX_DATA;
                        s_nxt.tx_bit = 3'h0;
                    end
                    TX_DATA:
                    begin
                        s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
                        s_nxt.tx_bit = s_r.tx_bit + 3'h1;
                        // R6: parity only when enabled
                        if (s_r.tx_bit == LAST_BIT)
                            s_nxt.tx_st = s_r.ctrl.parity_enable ? TX_PAR : TX_STOP1;
                    end
                    TX_PAR:
                        s_nxt.tx_st = TX_STOP1;
                    TX_STOP1:
                        // R5: second stop bit on request
                        s_nxt.tx_st = s_r.ctrl.tx_stop_length ? TX_STOP2 : TX_IDLE;
                    TX_STOP2:
                        s_nxt.tx_st = TX_IDLE;
                    default:
                        s_nxt.tx_st = TX_IDLE;
                endcase
                // R20: finished with nothing waiting
                if (s_nxt.tx_st == TX_IDLE && s_r.tx_buffer_empty_flag)
                    s_nxt.tx_done_flag = 1'b1;
            end
        end

        // R21: line level per frame position; R9: idle high
        unique case (s_nxt.tx_st)
            TX_START: s_nxt.txd = 1'b0;
            TX_DATA:  s_nxt.txd = s_nxt.tx_sh[0];
            TX_PAR:   s_nxt.txd = s_nxt.tx_par;
            default:  s_nxt.txd = 1'b1;
        endcase
    end

    // state register
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            s_r        <= '0;
            s_r.ctrl   <= ctrl_s'(CTRL_RST);
            s_r.period <= PERIOD_RST;
            s_r.tx_st  <= TX_IDLE;
            s_r.txd    <= 1'b1;
            s_r.tx_done_flag   <= 1'b1;
            s_r.tx_buffer_empty_flag   <= 1'b1;
            s_r.rxd_s1 <= 1'b1;
            s_r.rxd_s2 <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // outputs straight from flops
    assign RDATA_OUT  = s_r.rdata;
    assign TXD_OUT    = s_r.txd;
    assign TX_IRQ_OUT = s_r.tx_irq;
    assign RX_IRQ_OUT = s_r.rx_irq;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    sequence armed_write;
        wr_data && s_r.arm_tx && s_r.tx_buffer_empty_flag;
    endsequence
    sequence bare_write;
        wr_data && !s_r.arm_tx && s_r.tx_buffer_empty_flag;
    endsequence
    // last oversample step of the final stop bit, nothing waiting
    sequence last_stop;
        tick && s_r.tx_cnt == RT_END && s_r.tx_buffer_empty_flag
        && (s_r.tx_st == TX_STOP2
            || (s_r.tx_st == TX_STOP1 && !s_r.ctrl.tx_stop_length));
    endsequence

    AST_TX_IDLE_HIGH: assert property ( // R9
        (s_r.tx_st == TX_IDLE) |-> TXD_OUT)
        else $error("line not high while transmitter idle");
    AST_ARMED_WRITE: assert property ( // R7
        armed_write |=> (!s_r.tx_buffer_empty_flag && s_r.tx_hold == $past(WDATA_IN)))
        else $error("armed write did not fill the holding buffer");
    AST_BARE_WRITE: assert property ( // R10
        bare_write |=> s_r.tx_buffer_empty_flag)
        else $error("write without status read was taken");
    AST_START_FLAGS: assert property ( // R8
        tx_go |=> (s_r.tx_buffer_empty_flag && TX_IRQ_OUT && !s_r.tx_done_flag) ##1 !TXD_OUT)
        else $error("start did not empty buffer and pulse interrupt");
    AST_LOAD: assert property ( // R11
        (rx_done && !s_r.rbfl)
        |=> (s_r.rbfl && RX_IRQ_OUT && s_r.rx_buf == $past(rx_frame.data)))
        else $error("frame not loaded into the receive buffer");
    AST_OVERRUN: assert property ( // R13
        (rx_done && s_r.rbfl && !clr_rx)
        |=> (s_r.oerr && !RX_IRQ_OUT && $stable(s_r.rx_buf)))
        else $error("overrun did not keep the old byte");
    AST_CLEAR: assert property ( // R17
        (clr_rx && !rx_done) |=> (!s_r.parity_error_flag && !s_r.framing_error_flag && !s_r.rbfl))
        else $error("armed data read left a receive flag set");
    // no frame may complete while an overrun is pending
    AST_RX_HOLD: assert property ( // R18
        s_r.oerr |-> (!rx_run && !rx_done))
        else $error("receiver runs while overrun is set");
    // done flag follows the end of the last stop bit
    AST_TX_END: assert property ( // R20
        last_stop |=> (s_r.tx_done_flag && s_r.tx_st == TX_IDLE))
        else $error("done flag not set after final stop bit");
    // stop bits are always driven high
    AST_STOP_HIGH: assert property ( // R5
        (s_r.tx_st == TX_STOP1 || s_r.tx_st == TX_STOP2) |-> TXD_OUT)
        else $error("stop bit not high");
    // start bit is always driven low
    AST_START_LOW: assert property ( // R21
        (s_r.tx_st == TX_START) |-> !TXD_OUT)
        else $error("start bit not low");
endmodule
`default_nettype wire

// *** uart_pkg.sv ***
// shared constants, types and helpers for the async serial transceiver
package uart_pkg;

    // clocking and rate derivation
    localparam int CLK_HZ    = 50_000_000;      // system clock
    localparam int REF_HZ    = 16_000_000;      // source the rate table is quoted at
    localparam int BASE_BAUD = 76800;           // rate of select code 000
    localparam int OVS_RATE  = 16;              // oversample intervals per bit
    localparam int BASE_DIV  = CLK_HZ / (BASE_BAUD * OVS_RATE);
    localparam int SLOW_DIV  = CLK_HZ / (REF_HZ / 96);
    localparam int DIV_W     = 16;              // divider counter width

    // rate select codes
    localparam logic [2:0] SEL_FAST_MAX = 3'h5;
    localparam logic [2:0] SEL_TIMER    = 3'h6;

    // register offsets
    localparam logic [1:0] OFS_CTRL   = 2'h0;
    localparam logic [1:0] OFS_STATUS = 2'h1;
    localparam logic [1:0] OFS_DATA   = 2'h2;
    localparam logic [1:0] OFS_PERIOD = 2'h3;

    // values after reset
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'h01;

    // oversample positions inside one bit, and the last data bit index
    localparam logic [3:0] RT_FIRST = 4'h7;
    localparam logic [3:0] RT_MID   = 4'h8;
    localparam logic [3:0] RT_LAST  = 4'h9;
    localparam logic [3:0] RT_END   = 4'hf;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // control register layout, msb first
    typedef struct packed {
        logic [2:0] baud_divider_select;
        logic       parity_enable;
        logic       parity_even;
        logic       tx_stop_length;
        logic       receiver_enable_bit;
        logic       transmitter_enable_bit;
    } ctrl_s;

    // transmitter states
    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_START = 3'h1,
        TX_DATA  = 3'h2,
        TX_PAR   = 3'h3,
        TX_STOP1 = 3'h4,
        TX_STOP2 = 3'h5
    } tx_state_e;

    // receiver states
    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h2,
        RX_PAR   = 3'h3,
        RX_STOP  = 3'h4
    } rx_state_e;

    // one finished received frame
    typedef struct packed {
        logic [7:0] data;
        logic       par_err;
        logic       frm_err;
    } rx_frame_s;

    // parity bit for a byte; even selects even parity
    function automatic logic parity_bit(input logic [7:0] d, input logic even);
        parity_bit = even ? (^d) : ~(^d);
    endfunction

endpackage

// *** uart_rate_gen.sv ***
// oversample tick generator for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module uart_rate_gen
    import uart_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // rate selection
    input  wire logic [2:0] sel_in,
    input  wire logic       timer_tick_in,
    input  wire logic [7:0] period_in,
    // one pulse per oversample interval
    output logic            tick_out
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;    // cycles or timer ticks counted
        logic             tick;   // registered tick
    } rate_s;

    rate_s s_r;                   // state
    rate_s s_nxt;                 // next state
    logic [DIV_W-1:0] limit;      // terminal count

    // divider per select code
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        limit = DIV_W'(SLOW_DIV - 1);
        if (sel_in <= SEL_FAST_MAX)
            limit = DIV_W'((BASE_DIV << sel_in) - 1);
        // R2: timer period divides the timer source
        if (sel_in == SEL_TIMER)
        begin
            limit = DIV_W'(period_in) - DIV_W'(1);
            if (timer_tick_in && period_in != 8'h00)
            begin
                s_nxt.cnt = s_r.cnt + DIV_W'(1);
                if (s_r.cnt >= limit)
                begin
                    s_nxt.cnt = '0;
                    s_nxt.tick = 1'b1;
                end
            end
        end
        else
        begin
            // R1: halving steps of the fixed divider
            s_nxt.cnt = s_r.cnt + DIV_W'(1);
            if (s_r.cnt >= limit)
            begin
                s_nxt.cnt = '0;
                s_nxt.tick = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tick_out = s_r.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_BASE_RATE: assert property ( // R1
        (tick_out && sel_in == 3'h0 && $stable(sel_in)) |-> ##40 tick_out)
        else $error("fastest code does not tick every 40 cycles");
endmodule
`default_nettype wire

// *** uart_rx_frame.sv ***
// receive framer: start hunting, three point voting, frame checks
`timescale 1ns/1ps
`default_nettype none
module uart_rx_frame
    import uart_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // timing and line
    input  wire logic tick_in,
    input  wire logic rxd_in,
    // configuration
    input  wire logic run_in,
    input  wire logic par_en_in,
    input  wire logic even_in,
    // finished frame
    output logic      done_out,
    output rx_frame_s frame_out
);
    typedef struct packed {
        rx_state_e  st;       // frame position
        logic [3:0] cnt;      // oversample index in the bit
        logic [2:0] bit_i;    // data bit index
        logic [1:0] smp;      // first two votes
        logic [7:0] data;     // shifted data
        logic       done;     // frame pulse
        rx_frame_s  frame;    // held result
    } rx_s;

    rx_s  s_r;                // state
    rx_s  s_nxt;              // next state
    logic vote;               // majority of three samples
    logic [3:0] c;            // oversample index of this tick

    assign c = s_r.cnt + 4'h1;
    // R4: two of three agree
    assign vote = (s_r.smp[0] & s_r.smp[1]) | (rxd_in & (s_r.smp[0] | s_r.smp[1]));

    // bit timing and frame walk
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (tick_in)
        begin
            s_nxt.cnt = c;
            if (c == RT_FIRST)
                s_nxt.smp[0] = rxd_in;
            if (c == RT_MID)
                s_nxt.smp[1] = rxd_in;
            unique case (s_r.st)
                RX_IDLE:
                begin
                    // R3: hunt low level; R14: run only sampled here
                    s_nxt.cnt = 4'h0;
                    if (run_in && !rxd_in)
                        s_nxt.st = RX_START;
                end
                RX_START:
                    // R23: decision mid-bit, false start drops back
                    if (c == RT_LAST)
                    begin
                        s_nxt.st = vote ? RX_IDLE : RX_DATA;
                        s_nxt.bit_i = 3'h0;
                    end
                RX_DATA:
                    if (c == RT_LAST)
                    begin
                        s_nxt.data = {vote, s_r.data[7:1]};
                        s_nxt.bit_i = s_r.bit_i + 3'h1;
                        if (s_r.bit_i == LAST_BIT)
                            s_nxt.st = par_en_in ? RX_PAR : RX_STOP;
                    end
                RX_PAR:
                    // R15: compare against recomputed parity
                    if (c == RT_LAST)
                    begin
                        s_nxt.frame.par_err = vote != parity_bit(s_r.data, even_in);
                        s_nxt.st = RX_STOP;
                    end
                RX_STOP:
                    // R16: low stop bit is a framing error
                    if (c == RT_LAST)
                    begin
                        s_nxt.frame.frm_err = !vote;
                        s_nxt.frame.data = s_r.data;
                        s_nxt.done = 1'b1;
                        s_nxt.st = RX_IDLE;
                    end
                default:
                    s_nxt.st = RX_IDLE;
            endcase
            if (s_r.st == RX_IDLE)
                s_nxt.frame.par_err = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s_r <= '{st: RX_IDLE, default: '0};
        else
            s_r <= s_nxt;
    end

    assign done_out  = s_r.done;
    assign frame_out = s_r.frame;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence stop_vote;
        tick_in && s_r.st == RX_STOP && c == RT_LAST;
    endsequence

    AST_STOP_LOW_FRAMING_ERROR_FLAG: assert property ( // R16
        (stop_vote and (!vote)) |=> (done_out && frame_out.frm_err))
        else $error("low stop bit not flagged as framing error");
    AST_VOTE_DATA: assert property ( // R4
        (tick_in && s_r.st == RX_DATA && c == RT_LAST)
        |=> (s_r.data[7] == $past(vote)))
        else $error("data bit does not follow the majority vote");
endmodule
`default_nettype wire

// *** uart_line_model.sv ***
// remote serial partner: frame sender and transmit line decoder
`timescale 1ns/1ps
`default_nettype none
module uart_line_model #(parameter int BIT = 640)
(
    // clock
    input  wire logic       clk,
    // serial line
    input  wire logic       txd_in,
    output logic            rxd_out,
    // decoded frame: stop, parity, data
    output logic            got_stb,
    output logic      [9:0] got
);
    // idle line high
    initial
    begin
        rxd_out = 1'b1;
        got_stb = 1'b0;
        got = 10'h000;
    end
    task automatic send(input logic [7:0] d, input logic p, input logic s);
        logic [10:0] f;
        f = {s, p, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rxd_out <= f[i];
            repeat (BIT) @(posedge clk);
        end
        // idle gap so a low stop cannot look like a start
        rxd_out <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask
    // mid-bit decode of the transmit line
    always
    begin
        @(negedge txd_in);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            repeat (BIT) @(posedge clk);
            got[i] <= txd_in;
        end
        got_stb <= 1'b1;
        @(posedge clk);
        got_stb <= 1'b0;
    end
endmodule
`default_nettype wire

// *** test_uart_core.sv ***
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module test_uart_core;
    import uart_pkg::*;
    logic       CLK_IN, NRST_IN, WR_IN, RD_IN, TIMER_TICK_IN, RXD_IN, rd_pend;
    logic [1:0] ADDR_IN;
    logic [7:0] WDATA_IN, RDATA_OUT, b;
    logic       TXD_OUT, TX_IRQ_OUT, RX_IRQ_OUT, got_stb;
    logic [9:0] got, te;
    logic [7:0] re;
    int         bad_count, n_tests, n_txi, n_rxi;
    logic [7:0] rq[$];   // expected read data
    logic [9:0] tq[$];   // expected transmitted frames
    always #10 CLK_IN = ~CLK_IN;
    uart_core dut (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN),
        .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
        .TIMER_TICK_IN(TIMER_TICK_IN), .RXD_IN(RXD_IN), .TXD_OUT(TXD_OUT),
        .TX_IRQ_OUT(TX_IRQ_OUT), .RX_IRQ_OUT(RX_IRQ_OUT));
    uart_line_model line (.clk(CLK_IN), .txd_in(TXD_OUT), .rxd_out(RXD_IN),
        .got_stb(got_stb), .got(got));
    // one-cycle write strobe
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        ADDR_IN <= a;
        WDATA_IN <= d;
        WR_IN <= 1'b1;
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
        @(posedge CLK_IN);
    endtask
    // one-cycle read strobe, expectation noted
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        rq.push_back(e);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        @(posedge CLK_IN);
    endtask
    task automatic complete_run;
        $display("TB: %0d mismatches in %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // read data settled mid-cycle, one cycle after the strobe
    always @(negedge CLK_IN)
    begin
        // pop once, the macro names its operands twice
        if (rd_pend)
        begin
            re = rq.pop_front();
            `CHK(RDATA_OUT, re)
        end
        rd_pend = RD_IN;
    end
    // timer ticks, decoded frames, interrupt counts
    always @(posedge CLK_IN)
    begin
        TIMER_TICK_IN <= ($urandom_range(3) == 0);
        if (got_stb)
        begin
            te = tq.pop_front();
            `CHK(got, te)
        end
        n_txi += TX_IRQ_OUT;
        n_rxi += RX_IRQ_OUT;
    end
    // hang guard, well past the expected run
    initial
    begin
        repeat (90000) @(posedge CLK_IN);
        bad_count++;
        complete_run;
    end
    initial
    begin
        {CLK_IN, NRST_IN, WR_IN, RD_IN, TIMER_TICK_IN, rd_pend} = '0;
        ADDR_IN = 2'h0;
        WDATA_IN = 8'h00;
        b = $urandom(98018);
        repeat (5) @(posedge CLK_IN);
        NRST_IN <= 1'b1;
        @(posedge CLK_IN);
        `CHK(TXD_OUT, 1'b1)
        rd(2'h1, 8'h0c);
        // tx and rx on, even parity, one stop, fastest rate
        wr(2'h0, 8'h1b);
        repeat (100) @(posedge CLK_IN);
        `CHK(TXD_OUT, 1'b1)
        b = $urandom;
        rd(2'h1, 8'h0c);
        tq.push_back({1'b1, ^b, b});
        wr(2'h2, b);
        repeat (8000) @(posedge CLK_IN);
        // write with no status read since the last one is dropped
        wr(2'h2, 8'h55);
        repeat (8000) @(posedge CLK_IN);
        rd(2'h1, 8'h0c);
        // odd parity, two stop bits, control reads back
        wr(2'h0, 8'h17);
        rd(2'h0, 8'h17);
        b = $urandom;
        rd(2'h1, 8'h0c);
        tq.push_back({1'b1, ~^b, b});
        wr(2'h2, b);
        repeat (8500) @(posedge CLK_IN);
        rd(2'h1, 8'h0c);
        wr(2'h0, 8'h1b);
        b = $urandom;
        line.send(b, ^b, 1'b1);
        rd(2'h1, 8'h1c);
        rd(2'h2, b);
        rd(2'h1, 8'h0c);
        // wrong parity and low stop
        line.send(8'h81, 1'b1, 1'b0);
        rd(2'h1, 8'hdc);
        rd(2'h2, 8'h81);
        rd(2'h1, 8'h0c);
        // second frame into a full buffer
        line.send(8'h11, 1'b0, 1'b1);
        line.send(8'h22, 1'b0, 1'b1);
        rd(2'h1, 8'h3c);
        rd(2'h2, 8'h11);
        rd(2'h1, 8'h0c);
        `CHK(n_txi, 2)
        `CHK(n_rxi, 3)
        `CHK(tq.size(), 0)
        complete_run;
    end
endmodule
`default_nettype wire
